// file: fpmu_defines.svh
// Constants for the floating-point multiply, accumulate and compare unit.
// Assumes the includer uses the fpmu_pkg types alongside these.
`ifndef FPMU_DEFINES_SVH
`define FPMU_DEFINES_SVH
// Instruction fields
`define FPMU_MAJOR 6'h32
`define FPMU_F_MAJ 31:26
`define FPMU_F_RD 25:21
`define FPMU_F_SEC 7:0
// Secondary opcodes
`define FPMU_MUL_S 8'h02
`define FPMU_MADD_S 8'h07
`define FPMU_SFEQ_S 8'h08
`define FPMU_SFGE_S 8'h0b
`define FPMU_MUL_D 8'h12
`define FPMU_MADD_D 8'h17
`define FPMU_SFEQ_D 8'h18
`define FPMU_SFGT_D 8'h1a
`define FPMU_SFGE_D 8'h1b
// Number formats
`define FPMU_BIAS_D 14'sd1023
`define FPMU_BIAS_S 14'sd127
`define FPMU_EMAX_D 11'h7ff
`define FPMU_EMAX_S 11'h0ff
`define FPMU_BOX 32'hffffffff
// Reset values
`define FPMU_STATUS_RST 5'h00
`define FPMU_ACC_RST 64'h0
`endif

// file: fpmu_pipe_model.sv
// Pipeline-side model: the general register file that takes unit writebacks.
// Assumes writeback records arrive one clock after issue, as the unit drives them.
`timescale 1ns/1ps
`default_nettype none
module fpmu_pipe_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Writeback from the unit
   input wire fpmu_pkg::fpmu_wb_s wb
);
   logic [63:0] gpr_r [32];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < 32; i++) gpr_r[i] <= 64'h0;
      end else if (wb.valid && wb.we) begin
         gpr_r[wb.idx] <= wb.d1;
         // Second register of a pair takes the low word
         if (wb.pair) gpr_r[wb.idx + 5'h01] <= wb.d2;
      end
   end
endmodule
`default_nettype wire

// file: fpmu_pkg.sv
// Types shared by the floating-point multiply, accumulate and compare unit.
// Assumes nothing of its surroundings.
package fpmu_pkg;
   typedef struct packed {
      logic inv;
      logic infinity_status_flag;
      logic ovf;
      logic unf;
      logic ix;
   } fpmu_flags_s;
   typedef struct packed {
      logic sgn;
      logic zero;
      logic infinity_status_flag;
      logic nan;
      logic snan;
      logic signed [13:0] exp;
      logic [127:0] man;
   } fpmu_num_s;
   typedef struct packed {
      logic [63:0] v;
      fpmu_flags_s f;
   } fpmu_rres_s;
   typedef struct packed {
      logic valid;
      logic we;
      logic pair;
      logic [4:0] idx;
      logic [63:0] d1;
      logic [63:0] d2;
   } fpmu_wb_s;
endpackage

// file: fpmu_unit.sv
// Floating-point multiply, multiply-accumulate and compare execute unit.
// Assumes the pipeline presents already-read operands with one issue pulse
// per instruction, and takes results one clock later.
// Contract
// - Group opcode 0x32 on top six bits; secondary opcode in low byte.
// - Double accumulate adds product to high:low accumulator pair.
// - Accumulate multiplies and adds with a single final rounding.
// - Single accumulate is secondary 0x7; accumulator is its only target.
// - Single accumulate on 64-bit fills both accumulator upper halves with ones.
// - Double multiply is secondary 0x12, writing product to destination.
// - On 32-bit, double operands and results are pairs, first is high.
// - Single multiply is secondary 0x2, writing low 32 bits.
// - Single multiply on 64-bit sets destination upper half to ones.
// - Equal compares are 0x18 and 0x8; no register write.
// - Greater-or-equal compares are 0x1b and 0xb.
// - Double greater-than is 0x1a, destination field unused.
// - Compares set the compare flag to the relation's truth.
// - On 32-bit, double compares use concatenated pairs as 64-bit values.
// - Single compares use only bits 31 to 0.
// - Compare with an infinite input sets infinity flag and exception.
// - Equal compares flag invalid only for signaling NaN inputs.
// - Ordered compares flag invalid for any NaN input.
`timescale 1ns/1ps
`default_nettype none
`include "fpmu_defines.svh"
module fpmu_unit #(
   parameter int XLEN = 64
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Issue from the pipeline
   input wire logic issue_valid,
   input wire logic [31:0] instr,
   input wire logic [63:0] src_a1,
   input wire logic [63:0] src_a2,
   input wire logic [63:0] src_b1,
   input wire logic [63:0] src_b2,
   // Accumulator load from the pipeline
   input wire logic acc_wr_hi,
   input wire logic acc_wr_lo,
   input wire logic [63:0] acc_wr_data,
   // Status flag clear
   input wire logic status_clr,
   // Results
   output fpmu_pkg::fpmu_wb_s wb_r,
   output logic flag_we_r,
   output logic compare_flag_r,
   output logic fp_exception_r,
   output fpmu_pkg::fpmu_flags_s fp_status_r,
   output logic [63:0] acc_hi_r,
   output logic [63:0] acc_lo_r
);
   if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
      $error("fpmu_unit: XLEN must be 32 or 64");
   end

   function automatic logic [63:0] pk(input logic s, input logic [10:0] e, input logic [51:0] f,
                                      input logic dbl);
      pk = dbl ? {s, e, f} : {32'h0, s, e[7:0], f[51:29]};
   endfunction

   function automatic logic [63:0] qnan(input logic dbl);
      qnan = pk(1'b0, `FPMU_EMAX_D, {1'b1, 51'h0}, dbl);
   endfunction

   // Subnormal inputs are flushed to zero
   function automatic fpmu_pkg::fpmu_num_s unpk(input logic [63:0] x, input logic dbl);
      fpmu_pkg::fpmu_num_s n;
      logic [10:0] e;
      logic [51:0] f;
      logic emax;
      begin
         n = '0;
         e = dbl ? x[62:52] : {3'h0, x[30:23]};
         f = dbl ? x[51:0] : {x[22:0], 29'h0};
         emax = (e == (dbl ? `FPMU_EMAX_D : `FPMU_EMAX_S));
         n.sgn = dbl ? x[63] : x[31];
         n.zero = (e == 11'h0);
         n.infinity_status_flag = emax && (f == 52'h0);
         n.nan = emax && (f != 52'h0);
         n.snan = n.nan && !f[51];
         n.exp = $signed({3'h0, e}) - (dbl ? `FPMU_BIAS_D : `FPMU_BIAS_S);
         n.man = {1'b1, f, 75'h0};
         unpk = n;
      end
   endfunction

   // Exact product, normalised with the leading one at bit 127
   function automatic fpmu_pkg::fpmu_num_s mulx(input fpmu_pkg::fpmu_num_s x,
                                                input fpmu_pkg::fpmu_num_s y);
      fpmu_pkg::fpmu_num_s n;
      logic [105:0] pr;
      begin
         pr = x.man[127:75] * y.man[127:75];
         n = '0;
         n.sgn = x.sgn ^ y.sgn;
         n.zero = x.zero | y.zero;
         n.infinity_status_flag = x.infinity_status_flag | y.infinity_status_flag;
         n.exp = x.exp + y.exp + {13'h0, pr[105]};
         n.man = pr[105] ? {pr, 22'h0} : {pr[104:0], 23'h0};
         mulx = n;
      end
   endfunction

   // Round to nearest even; results too small are flushed to zero
   function automatic fpmu_pkg::fpmu_rres_s rnd(input fpmu_pkg::fpmu_num_s n, input logic dbl);
      fpmu_pkg::fpmu_rres_s r;
      logic [53:0] k;
      logic g;
      logic st;
      logic signed [13:0] be;
      logic [51:0] fr;
      begin
         r = '0;
         k = dbl ? {1'b0, n.man[127:75]} : {30'h0, n.man[127:104]};
         g = dbl ? n.man[74] : n.man[103];
         st = dbl ? |n.man[73:0] : |n.man[102:0];
         k = k + {53'h0, g & (st | k[0])};
         be = n.exp + (dbl ? `FPMU_BIAS_D : `FPMU_BIAS_S);
         if (dbl ? k[53] : k[24]) begin
            be = be + 14'sd1;
         end
         fr = dbl ? k[51:0] : {k[22:0], 29'h0};
         r.f.ix = g | st;
         if (be >= (dbl ? 14'sd2047 : 14'sd255)) begin
            r.f.ovf = 1'b1;
            r.f.infinity_status_flag = 1'b1;
            r.f.ix = 1'b1;
            r.v = pk(n.sgn, `FPMU_EMAX_D, 52'h0, dbl);
         end else if (be <= 14'sd0) begin
            r.f.unf = 1'b1;
            r.f.ix = 1'b1;
            r.v = pk(n.sgn, 11'h0, 52'h0, dbl);
         end else begin
            r.v = pk(n.sgn, be[10:0], fr, dbl);
         end
         rnd = r;
      end
   endfunction

   function automatic fpmu_pkg::fpmu_rres_s fmul(input logic [63:0] a, input logic [63:0] b,
                                                 input logic dbl);
      fpmu_pkg::fpmu_rres_s r;
      fpmu_pkg::fpmu_num_s x;
      fpmu_pkg::fpmu_num_s y;
      fpmu_pkg::fpmu_num_s p;
      begin
         r = '0;
         x = unpk(a, dbl);
         y = unpk(b, dbl);
         p = mulx(x, y);
         if (x.nan | y.nan | (p.infinity_status_flag & p.zero)) begin
            r.v = qnan(dbl);
            r.f.inv = x.snan | y.snan | (!(x.nan | y.nan) & p.infinity_status_flag & p.zero);
         end else if (p.infinity_status_flag) begin
            r.v = pk(p.sgn, `FPMU_EMAX_D, 52'h0, dbl);
            r.f.infinity_status_flag = 1'b1;
         end else if (p.zero) begin
            r.v = pk(p.sgn, 11'h0, 52'h0, dbl);
         end else begin
            r = rnd(p, dbl);
         end
         fmul = r;
      end
   endfunction

   // Accumulator always holds a double; the exact product is added unrounded
   function automatic fpmu_pkg::fpmu_rres_s fmadd(input logic [63:0] a, input logic [63:0] b,
                                                  input logic [63:0] c, input logic dbl);
      fpmu_pkg::fpmu_rres_s r;
      fpmu_pkg::fpmu_num_s x;
      fpmu_pkg::fpmu_num_s y;
      fpmu_pkg::fpmu_num_s p;
      fpmu_pkg::fpmu_num_s q;
      fpmu_pkg::fpmu_num_s bg;
      fpmu_pkg::fpmu_num_s sm;
      logic [130:0] sv;
      logic [130:0] rv;
      logic [13:0] d;
      logic [7:0] msb;
      logic nan_in;
      begin
         r = '0;
         x = unpk(a, dbl);
         y = unpk(b, dbl);
         q = unpk(c, 1'b1);
         p = mulx(x, y);
         nan_in = x.nan | y.nan | q.nan;
         if (nan_in | (p.infinity_status_flag & p.zero) | (p.infinity_status_flag & q.infinity_status_flag & (p.sgn != q.sgn))) begin
            r.v = qnan(1'b1);
            r.f.inv = x.snan | y.snan | q.snan | (!nan_in & p.infinity_status_flag);
         end else if (p.infinity_status_flag | q.infinity_status_flag) begin
            r.v = pk(p.infinity_status_flag ? p.sgn : q.sgn, `FPMU_EMAX_D, 52'h0, 1'b1);
            r.f.infinity_status_flag = 1'b1;
         end else if (p.zero) begin
            r.v = c;
         end else if (q.zero) begin
            r = rnd(p, 1'b1);
         end else begin
            if ((p.exp > q.exp) || ((p.exp == q.exp) && (p.man >= q.man))) begin
               bg = p;
               sm = q;
            end else begin
               bg = q;
               sm = p;
            end
            d = bg.exp - sm.exp;
            sv = {1'b0, sm.man, 2'b0};
            // Bits shifted out still count toward the sticky bit
            if (d > 14'd130) begin
               sv = {130'h0, 1'b1};
            end else begin
               sv = (sv >> d) | {130'h0, |(sv & ~({131{1'b1}} << d))};
            end
            rv = (bg.sgn != sm.sgn) ? {1'b0, bg.man, 2'b0} - sv : {1'b0, bg.man, 2'b0} + sv;
            if (rv == 131'h0) begin
               r.v = 64'h0;
            end else begin
               msb = 8'h0;
               for (int i = 0; i < 131; i++) begin
                  if (rv[i]) begin
                     msb = 8'(i);
                  end
               end
               rv = rv << (8'd130 - msb);
               bg.man = {rv[130:4], |rv[3:0]};
               bg.exp = bg.exp + $signed({6'h0, msb}) - 14'sd129;
               r = rnd(bg, 1'b1);
            end
         end
         fmadd = r;
      end
   endfunction

   // Order-preserving key for compares
   function automatic logic [63:0] okey(input logic [63:0] x, input logic dbl);
      logic [63:0] v;
      begin
         v = dbl ? x : {x[31:0], 32'h0};
         okey = v[63] ? ~v : {1'b1, v[62:0]};
      end
   endfunction

   logic iss;
   logic [7:0] sec;
   logic is_d;
   logic op_mul;
   logic op_madd;
   logic op_eq;
   logic op_ge;
   logic op_gt;
   logic op_cmp;
   logic [63:0] a64;
   logic [63:0] b64;
   logic [63:0] acc64;
   fpmu_pkg::fpmu_rres_s mul_res;
   fpmu_pkg::fpmu_rres_s madd_res;
   fpmu_pkg::fpmu_num_s xa;
   fpmu_pkg::fpmu_num_s xb;
   logic any_nan;
   logic both_zero;
   logic c_eq;
   logic c_gt;
   logic c_res;
   fpmu_pkg::fpmu_flags_s cmp_f;
   fpmu_pkg::fpmu_flags_s new_f;
   logic [31:0] box;

   assign iss = issue_valid && (instr[`FPMU_F_MAJ] == `FPMU_MAJOR);
   assign sec = instr[`FPMU_F_SEC];
   assign is_d = sec[4];
   assign box = (XLEN == 64) ? `FPMU_BOX : 32'h0;

   always_comb begin
      op_mul = 1'b0;
      op_madd = 1'b0;
      op_eq = 1'b0;
      op_ge = 1'b0;
      op_gt = 1'b0;
      case (sec)
         `FPMU_MUL_S, `FPMU_MUL_D: op_mul = iss;
         `FPMU_MADD_S, `FPMU_MADD_D: op_madd = iss;
         `FPMU_SFEQ_S, `FPMU_SFEQ_D: op_eq = iss;
         `FPMU_SFGE_S, `FPMU_SFGE_D: op_ge = iss;
         `FPMU_SFGT_D: op_gt = iss;
         default: ;
      endcase
   end
   assign op_cmp = op_eq | op_ge | op_gt;

   // Pairs put the first register on top
   assign a64 = !is_d ? {32'h0, src_a1[31:0]} :
                (XLEN == 32) ? {src_a1[31:0], src_a2[31:0]} : src_a1;
   assign b64 = !is_d ? {32'h0, src_b1[31:0]} :
                (XLEN == 32) ? {src_b1[31:0], src_b2[31:0]} : src_b1;
   assign acc64 = {acc_hi_r[31:0], acc_lo_r[31:0]};

   assign mul_res = fmul(a64, b64, is_d);
   assign madd_res = fmadd(a64, b64, acc64, is_d);

   assign xa = unpk(a64, is_d);
   assign xb = unpk(b64, is_d);
   assign any_nan = xa.nan | xb.nan;
   assign both_zero = xa.zero & xb.zero;
   assign c_eq = !any_nan && (both_zero || (okey(a64, is_d) == okey(b64, is_d)));
   assign c_gt = !any_nan && !both_zero && (okey(a64, is_d) > okey(b64, is_d));
   assign c_res = op_eq ? c_eq : op_gt ? c_gt : (c_eq | c_gt);

   always_comb begin
      cmp_f = '0;
      cmp_f.infinity_status_flag = xa.infinity_status_flag | xb.infinity_status_flag;
      cmp_f.inv = op_eq ? (xa.snan | xb.snan) : any_nan;
      new_f = op_mul ? mul_res.f : op_madd ? madd_res.f : op_cmp ? cmp_f : '0;
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fp_status_r <= `FPMU_STATUS_RST;
         fp_exception_r <= 1'b0;
      end else begin
         fp_status_r <= (fp_status_r & ~{5{status_clr}}) | new_f;
         fp_exception_r <= |new_f;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flag_we_r <= 1'b0;
         compare_flag_r <= 1'b0;
      end else begin
         flag_we_r <= op_cmp;
         if (op_cmp) begin
            compare_flag_r <= c_res;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wb_r <= '0;
      end else begin
         wb_r.valid <= op_mul | op_madd | op_cmp;
         wb_r.we <= op_mul;
         wb_r.pair <= op_mul && is_d && (XLEN == 32);
         wb_r.idx <= instr[`FPMU_F_RD];
         if (!is_d) begin
            wb_r.d1 <= {box, mul_res.v[31:0]};
            wb_r.d2 <= 64'h0;
         end else if (XLEN == 32) begin
            wb_r.d1 <= {32'h0, mul_res.v[63:32]};
            wb_r.d2 <= {32'h0, mul_res.v[31:0]};
         end else begin
            wb_r.d1 <= mul_res.v;
            wb_r.d2 <= 64'h0;
         end
      end
   end

   // An accumulate in the same cycle overrides a pipeline load
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc_hi_r <= `FPMU_ACC_RST;
         acc_lo_r <= `FPMU_ACC_RST;
      end else if (op_madd) begin
         acc_hi_r <= {is_d ? 32'h0 : box, madd_res.v[63:32]};
         acc_lo_r <= {is_d ? 32'h0 : box, madd_res.v[31:0]};
      end else begin
         if (acc_wr_hi) begin
            acc_hi_r <= acc_wr_data;
         end
         if (acc_wr_lo) begin
            acc_lo_r <= acc_wr_data;
         end
      end
   end

   a_major_gate: assert property (
      @(posedge clk_sys) disable iff (srst)
      (instr[`FPMU_F_MAJ] != `FPMU_MAJOR) |=> !wb_r.valid && !flag_we_r)
      else $error("op outside the group was executed");

   a_mul_box: assert property (
      @(posedge clk_sys) disable iff (srst)
      (op_mul && !is_d && XLEN == 64) |=> wb_r.we && (wb_r.d1[63:32] == 32'hffffffff))
      else $error("single multiply result not boxed");

   a_mul_dest: assert property (
      @(posedge clk_sys) disable iff (srst)
      op_mul |=> wb_r.we && (wb_r.idx == $past(instr[25:21])))
      else $error("multiply did not write its destination");

   a_madd_box: assert property (
      @(posedge clk_sys) disable iff (srst)
      (op_madd && !is_d && XLEN == 64) |=>
      (acc_hi_r[63:32] == 32'hffffffff) && (acc_lo_r[63:32] == 32'hffffffff) && !wb_r.we)
      else $error("single accumulate not boxed or wrote a register");

   a_cmp_nowrite: assert property (
      @(posedge clk_sys) disable iff (srst)
      op_cmp |=> flag_we_r && !wb_r.we)
      else $error("compare wrote a register or missed the flag");

   a_cmp_equal: assert property (
      @(posedge clk_sys) disable iff (srst)
      (op_eq && !any_nan && a64 == b64) |=> flag_we_r && compare_flag_r)
      else $error("equal operands did not set the compare flag");

   a_gt_nan: assert property (
      @(posedge clk_sys) disable iff (srst)
      ((op_gt || op_ge) && any_nan) |=> !compare_flag_r && fp_status_r.inv)
      else $error("ordered compare with NaN mishandled");

   a_eq_quiet: assert property (
      @(posedge clk_sys) disable iff (srst)
      (op_eq && !xa.snan && !xb.snan && !fp_status_r.inv) |=> !fp_status_r.inv)
      else $error("quiet NaN equal compare raised invalid");

   a_inf_flag: assert property (
      @(posedge clk_sys) disable iff (srst)
      (op_cmp && (xa.infinity_status_flag || xb.infinity_status_flag)) |=> fp_status_r.infinity_status_flag && fp_exception_r)
      else $error("infinite compare input not reported");

   a_status_sticky: assert property (
      @(posedge clk_sys) disable iff (srst)
      (fp_status_r.inv && !status_clr) |=> fp_status_r.inv [*1] ##0 ($stable(fp_status_r.inv)))
      else $error("status flag lost without a clear");
endmodule
`default_nettype wire

// file: fpmu_unit_tb.sv
// Testbench for the multiply, accumulate and compare unit at both widths.
// Assumes both units see the same instruction stream and only differ in operand layout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module fpmu_unit_tb;
   typedef struct packed {
      logic [7:0] s;
      logic [63:0] a;
      logic [63:0] b;
      logic f;
      logic [4:0] st;
   } fpmu_cmp_s;
   localparam logic [63:0] d_two = 64'h40000000_00000000;
   localparam logic [63:0] d_three = 64'h40080000_00000000;
   localparam logic [63:0] d_inf = 64'h7ff00000_00000000;
   localparam logic [63:0] d_qnan = 64'h7ff80000_00000000;
   localparam logic [63:0] s_two = 64'h40000000;
   localparam logic [63:0] s_three = 64'h40400000;
   localparam logic [63:0] s_qnan = 64'h7fc00000;
   localparam logic [63:0] s_snan = 64'h7fa00000;
   logic clk_sys, srst, issue_valid, acc_wr_hi, acc_wr_lo, status_clr;
   logic [31:0] instr;
   logic [63:0] a1, a2, b1, b2, n_a1, n_a2, n_b1, n_b2, acc_wr_data;
   fpmu_pkg::fpmu_wb_s wb_w, wb_n;
   fpmu_pkg::fpmu_flags_s st_w, st_n;
   logic fwe_w, fwe_n, cf_w, cf_n, exc_w, exc_n;
   logic [63:0] ahi_w, alo_w, ahi_n, alo_n;
   int num_errors = 0;
   int total_checks = 0;
   fpmu_cmp_s cmp_tab [15];

   fpmu_unit #(.XLEN(64)) fpmu_unit_inst (.clk_sys(clk_sys), .srst(srst), .issue_valid(issue_valid),
      .instr(instr), .src_a1(a1), .src_a2(a2), .src_b1(b1), .src_b2(b2), .acc_wr_hi(acc_wr_hi),
      .acc_wr_lo(acc_wr_lo), .acc_wr_data(acc_wr_data), .status_clr(status_clr), .wb_r(wb_w),
      .flag_we_r(fwe_w), .compare_flag_r(cf_w), .fp_exception_r(exc_w), .fp_status_r(st_w),
      .acc_hi_r(ahi_w), .acc_lo_r(alo_w));
   fpmu_unit #(.XLEN(32)) fpmu_unit_inst_n (.clk_sys(clk_sys), .srst(srst), .issue_valid(issue_valid),
      .instr(instr), .src_a1(n_a1), .src_a2(n_a2), .src_b1(n_b1), .src_b2(n_b2), .acc_wr_hi(acc_wr_hi),
      .acc_wr_lo(acc_wr_lo), .acc_wr_data(acc_wr_data), .status_clr(status_clr), .wb_r(wb_n),
      .flag_we_r(fwe_n), .compare_flag_r(cf_n), .fp_exception_r(exc_n), .fp_status_r(st_n),
      .acc_hi_r(ahi_n), .acc_lo_r(alo_n));
   fpmu_pipe_model fpmu_pipe_model_inst (.clk_sys(clk_sys), .srst(srst), .wb(wb_w));
   fpmu_pipe_model fpmu_pipe_model_inst_n (.clk_sys(clk_sys), .srst(srst), .wb(wb_n));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic stop_test();
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Narrow unit gets doubles split into pairs; wide unit sees junk in the unused second source
   task automatic op(input logic [5:0] maj, input logic [7:0] sec, input logic [4:0] rd,
         input logic [63:0] va, input logic [63:0] vb);
      @(posedge clk_sys);
      issue_valid <= 1'b1;
      instr <= {maj, rd, 5'h01, 5'h02, 3'h0, sec};
      a1 <= va;
      b1 <= vb;
      a2 <= ~va;
      b2 <= ~vb;
      n_a1 <= sec[4] ? {32'h0, va[63:32]} : va;
      n_a2 <= {32'h0, va[31:0]};
      n_b1 <= sec[4] ? {32'h0, vb[63:32]} : vb;
      n_b2 <= {32'h0, vb[31:0]};
      @(posedge clk_sys);
      issue_valid <= 1'b0;
      #1;
   endtask

   task automatic ld(input logic hi, input logic [63:0] d);
      @(posedge clk_sys);
      acc_wr_hi <= hi;
      acc_wr_lo <= ~hi;
      acc_wr_data <= d;
      @(posedge clk_sys);
      acc_wr_hi <= 1'b0;
      acc_wr_lo <= 1'b0;
   endtask

   task automatic clr();
      @(posedge clk_sys);
      status_clr <= 1'b1;
      @(posedge clk_sys);
      status_clr <= 1'b0;
      #1;
      `CHK("status clear", 5'h00, st_w)
      `CHK("status clear n", 5'h00, st_n)
   endtask

   task automatic t_refuse();
      `CHK("reset acc", 64'h0, ahi_w)
      op(6'h31, 8'h02, 5'h06, s_two, s_three);
      `CHK("bad major", 1'b0, wb_w.valid)
      op(6'h32, 8'h0a, 5'h06, s_two, s_three);
      `CHK("bad minor", 2'b00, {wb_w.valid, fwe_n})
   endtask

   task automatic t_mul();
      op(6'h32, 8'h02, 5'h03, 64'hdeadbeef_40000000, 64'h01234567_40400000);
      `CHK("mul_s wb", 64'hffffffff_40c00000, wb_w.d1)
      `CHK("mul_s wb n", 64'h40c00000, wb_n.d1)
      `CHK("mul_s ctl", 2'b11, {wb_w.valid, wb_w.we})
      `CHK("mul_s exc", 1'b0, exc_w)
      // Odd low word makes the second register of the pair carry data
      op(6'h32, 8'h12, 5'h04, 64'h3ff00000_00000001, d_two);
      `CHK("mul_d pair", 1'b1, wb_n.pair)
      `CHK("mul_d rd", 5'h04, wb_w.idx)
      @(posedge clk_sys);
      #1;
      `CHK("gpr mul_s", 64'hffffffff_40c00000, fpmu_pipe_model_inst.gpr_r[3])
      `CHK("gpr mul_d", 64'h40000000_00000001, fpmu_pipe_model_inst.gpr_r[4])
      `CHK("gpr hi n", 64'h40000000, fpmu_pipe_model_inst_n.gpr_r[4])
      `CHK("gpr lo n", 64'h00000001, fpmu_pipe_model_inst_n.gpr_r[5])
   endtask

   task automatic t_ovf();
      op(6'h32, 8'h12, 5'h05, 64'h7fefffff_ffffffff, d_two);
      `CHK("ovf res", d_inf, wb_w.d1)
      `CHK("ovf flags", 5'h0d, st_w)
      `CHK("ovf exc", 1'b1, exc_n)
      clr();
   endtask

   task automatic t_madd();
      ld(1'b1, 64'h3ff00000);
      ld(1'b0, 64'h0);
      op(6'h32, 8'h07, 5'h1f, s_two, s_three);
      `CHK("mac_s ctl", 2'b10, {wb_w.valid, wb_w.we})
      `CHK("mac_s hi", 64'hffffffff_401c0000, ahi_w)
      `CHK("mac_s lo", 64'hffffffff_00000000, alo_w)
      `CHK("mac_s hi n", 32'h401c0000, ahi_n[31:0])
      // Product 1 - 2^-60 would round to 1.0 if rounded before the add
      ld(1'b1, 64'hbff00000);
      ld(1'b0, 64'h0);
      op(6'h32, 8'h17, 5'h00, 64'h3ff00000_00400000, 64'h3fefffff_ff800000);
      `CHK("mac_d hi", 64'hbc300000, ahi_w)
      `CHK("mac_d lo", 64'h0, alo_w)
      `CHK("mac_d n", 64'hbc300000_00000000, {ahi_n[31:0], alo_n[31:0]})
   endtask

   task automatic t_cmp();
      foreach (cmp_tab[i]) begin
         op(6'h32, cmp_tab[i].s, 5'h1f, cmp_tab[i].a, cmp_tab[i].b);
         `CHK("cmp flag", cmp_tab[i].f, cf_w)
         `CHK("cmp flag n", cmp_tab[i].f, cf_n)
         `CHK("cmp ctl", 3'b110, {fwe_w, wb_w.valid, wb_w.we})
         `CHK("cmp status", cmp_tab[i].st, st_w)
         `CHK("cmp status n", cmp_tab[i].st, st_n)
         `CHK("cmp exc", |cmp_tab[i].st, exc_w)
         if (cmp_tab[i].st !== 5'h00) clr();
      end
   endtask

   initial begin
      srst = 1'b1;
      {issue_valid, acc_wr_hi, acc_wr_lo, status_clr} = 4'h0;
      instr = 32'h0;
      {a1, a2, b1, b2, n_a1, n_a2, n_b1, n_b2, acc_wr_data} = '0;
      cmp_tab = '{
         '{8'h18, d_two, d_two, 1'b1, 5'h00},
         '{8'h18, d_two, d_three, 1'b0, 5'h00},
         '{8'h1b, d_two, d_three, 1'b0, 5'h00},
         '{8'h1b, d_three, d_three, 1'b1, 5'h00},
         '{8'h1a, d_three, d_three, 1'b0, 5'h00},
         '{8'h1a, d_three, d_two, 1'b1, 5'h00},
         '{8'h1a, 64'h3ff00000_00000001, 64'h3ff00000_00000000, 1'b1, 5'h00},
         '{8'h08, 64'h12345678_40000000, s_two, 1'b1, 5'h00},
         '{8'h0b, s_two, s_three, 1'b0, 5'h00},
         '{8'h0b, s_three, s_three, 1'b1, 5'h00},
         '{8'h18, d_inf, d_two, 1'b0, 5'h08},
         '{8'h08, s_qnan, s_two, 1'b0, 5'h00},
         '{8'h08, s_snan, s_two, 1'b0, 5'h10},
         '{8'h0b, s_qnan, s_two, 1'b0, 5'h10},
         '{8'h1a, d_qnan, d_two, 1'b0, 5'h10}
      };
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      t_refuse();
      t_mul();
      t_ovf();
      t_madd();
      t_cmp();
      stop_test();
   end

   // Whole run needs under a hundred cycles; this leaves ample margin
   initial begin
      #(20 * 5000);
      num_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
